// ### design/uqm_monitor.sv
`include "uqm_defines.svh"
module uqm_monitor #(
  parameter int NCNT  = 8,
  parameter int NCORE = 4,
  parameter int CW    = 48
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [11:0]      s_axi_awaddr_i,
  input  wire logic             s_axi_awvalid_i,
  output logic                  s_axi_awready_o,
  input  wire logic [31:0]      s_axi_wdata_i,
  input  wire logic [3:0]       s_axi_wstrb_i,
  input  wire logic             s_axi_wvalid_i,
  output logic                  s_axi_wready_o,
  output logic [1:0]            s_axi_bresp_o,
  output logic                  s_axi_bvalid_o,
  input  wire logic             s_axi_bready_i,
  input  wire logic [11:0]      s_axi_araddr_i,
  input  wire logic             s_axi_arvalid_i,
  output logic                  s_axi_arready_o,
  output logic [31:0]           s_axi_rdata_o,
  output logic [1:0]            s_axi_rresp_o,
  output logic                  s_axi_rvalid_o,
  input  wire logic             s_axi_rready_i,
  input  wire logic [2:0]       trk_alloc_i,
  input  wire logic [2:0]       trk_dealloc_i,
  input  wire logic             rd_miss_i,
  input  wire logic             rd_resp_i,
  input  wire logic             rd_credit_i,
  input  wire logic             uncore_halt_i,
  output logic [NCORE-1:0]      core_signal_o,
  output logic                  irq_o
);
  import uqm_pkg::*;

  uqm_trk_sample_type samp [6];
  logic [CW-1:0]      fixed_q;
  logic               fixed_ovf_q;
  logic [CW:0]        fixed_sum;
  logic [31:0]        ctrl_q;
  logic [NCNT:0]      status_q;
  logic [NCNT:0]      mask_q;
  logic [NCORE-1:0]   core_sel_q;
  logic [NCORE-1:0]   core_sig_q;
  logic [31:0]        sel_q [NCNT];
  logic [CW-1:0]      cnt_val [NCNT];
  logic [NCNT:0]      ovf_ev;
  logic [NCNT-1:0]    load_lo;
  logic               glob_en;

  // write channel state: address and data accepted in any order
  logic               aw_have_q;
  logic               w_have_q;
  logic [11:0]        aw_addr_q;
  logic [31:0]        w_data_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;
  logic               wr_fire;
  logic               wr_hit;
  logic               rd_fire;
  logic               rd_hit;
  logic [31:0]        rd_mux;
  logic [31:0]        wmask;
  logic [31:0]        wr_val;

  uqm_trackers u_trk (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .alloc_i     (trk_alloc_i),
    .dealloc_i   (trk_dealloc_i),
    .rd_miss_i   (rd_miss_i),
    .rd_resp_i   (rd_resp_i),
    .rd_credit_i (rd_credit_i),
    .samp_o      (samp)
  );

  assign glob_en = ctrl_q[0];

  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    uqm_evt_if #(.W(CW)) evt ();
    assign evt.evt_code  = sel_q[i][`UQM_SEL_EVT_LSB +: 8];
    assign evt.unit_mask = sel_q[i][`UQM_SEL_UM_LSB +: 8];
    assign evt.threshold = sel_q[i][`UQM_SEL_THR_LSB +: 8];
    assign evt.enable    = glob_en && sel_q[i][`UQM_SEL_EN_BIT];
    assign cnt_val[i]    = evt.count;
    assign ovf_ev[i]     = evt.overflow;
    assign load_lo[i]    = wr_fire &&
                           aw_addr_q == 12'(`UQM_OFF_CNT_BASE + 4 * i);
    uqm_counter #(.W(CW)) u_cnt (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .cfg         (evt),
      .samp_i      (samp),
      .load_i      (load_lo[i]),
      .load_data_i (w_wr_data(i))
    );
  end

  function automatic logic [31:0] w_wr_data(input int idx);
    w_wr_data = w_data_q;
  endfunction

  // fixed counter free of event select; halt freezes the count, not the uncore clock itself
  assign fixed_sum = {1'b0, fixed_q} + {{CW{1'b0}}, 1'b1};
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fixed_q     <= '0;
      fixed_ovf_q <= 1'b0;
    end else if (wr_fire && aw_addr_q == `UQM_OFF_FIXED) begin
      fixed_q     <= CW'(w_data_q);
      fixed_ovf_q <= 1'b0;
    end else if (glob_en && !uncore_halt_i) begin
      fixed_q     <= fixed_sum[CW-1:0];
      fixed_ovf_q <= fixed_sum[CW];
    end else begin
      fixed_ovf_q <= 1'b0;
    end
  end
  assign ovf_ev[`UQM_FIXED_BIT] = fixed_ovf_q;

  // write path
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit  = aw_addr_q == `UQM_OFF_CTRL || aw_addr_q == `UQM_OFF_STATUS ||
                   aw_addr_q == `UQM_OFF_MASK || aw_addr_q == `UQM_OFF_CORE_SEL ||
                   aw_addr_q == `UQM_OFF_FIXED ||
                   (aw_addr_q >= `UQM_OFF_SEL_BASE &&
                    aw_addr_q < 12'(`UQM_OFF_SEL_BASE + 4 * NCNT)) ||
                   (aw_addr_q >= `UQM_OFF_CNT_BASE &&
                    aw_addr_q < 12'(`UQM_OFF_CNT_BASE + 4 * NCNT));
  assign s_axi_awready_o = !aw_have_q;
  assign s_axi_wready_o  = !w_have_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                  {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  assign wr_val = s_axi_wdata_i & wmask;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      bvalid_q  <= 1'b0;
      bresp_q   <= `UQM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr_i[11:2], 2'b00};
      end
      if (s_axi_wvalid_i && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= wr_val;
      end
      if (wr_fire) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `UQM_RESP_OKAY : `UQM_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  // config registers; byte lanes zero-masked, so partial writes clear lanes
  for (genvar i = 0; i < NCNT; i++) begin : g_sel
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) sel_q[i] <= 32'h0000_0000;
      else if (wr_fire && aw_addr_q == 12'(`UQM_OFF_SEL_BASE + 4 * i))
        sel_q[i] <= w_data_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl_q     <= 32'h0000_0000;
      mask_q     <= '0;
      core_sel_q <= '0;
    end else if (wr_fire) begin
      if (aw_addr_q == `UQM_OFF_CTRL)     ctrl_q     <= w_data_q;
      if (aw_addr_q == `UQM_OFF_MASK)     mask_q     <= w_data_q[NCNT:0];
      if (aw_addr_q == `UQM_OFF_CORE_SEL) core_sel_q <= w_data_q[NCORE-1:0];
    end
  end

  // sticky overflow flags, write one to clear; a new overflow wins over clear
  logic [NCNT:0] st_clr;
  assign st_clr = (wr_fire && aw_addr_q == `UQM_OFF_STATUS) ? w_data_q[NCNT:0] : '0;
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) status_q <= '0;
    else         status_q <= (status_q & ~st_clr) | ovf_ev;
  end

  // masked overflow pulses the programmed core pattern; irq_o is the level of the masked sticky flags
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) core_sig_q <= '0;
    else         core_sig_q <= (|(ovf_ev & mask_q)) ? core_sel_q : '0;
  end
  assign core_signal_o = core_sig_q;
  assign irq_o         = |(status_q & mask_q);

  // read path
  assign rd_fire = s_axi_arvalid_i && !rvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  logic [11:0] ra;
  logic [3:0]  ri;
  assign ra = {s_axi_araddr_i[11:2], 2'b00};
  assign ri = ra[5:2];
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ra == `UQM_OFF_CTRL)           rd_mux = ctrl_q;
    else if (ra == `UQM_OFF_STATUS)    rd_mux = 32'(status_q);
    else if (ra == `UQM_OFF_MASK)      rd_mux = 32'(mask_q);
    else if (ra == `UQM_OFF_CORE_SEL)  rd_mux = 32'(core_sel_q);
    else if (ra == `UQM_OFF_FIXED)     rd_mux = 32'(fixed_q);
    else if (ra[11:6] == `UQM_OFF_SEL_BASE >> 6 && 32'(ri) < NCNT)
      rd_mux = sel_q[ri[2:0]];
    else if (ra[11:6] == `UQM_OFF_CNT_BASE >> 6 && 32'(ri) < NCNT)
      rd_mux = 32'(cnt_val[ri[2:0]]);
    else rd_hit = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `UQM_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? `UQM_RESP_OKAY : `UQM_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // queue drain before first occupancy use is left to software

  fixed_step_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    glob_en && !uncore_halt_i && !wr_fire && fixed_q != '1
    |=> fixed_q == $past(fixed_q) + 1'b1)
    else $error("fixed counter missed a cycle");
  core_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    |(ovf_ev & mask_q) |=> core_signal_o == $past(core_sel_q))
    else $error("core pattern not driven on overflow");
  core_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !(|(ovf_ev & mask_q)) |=> core_signal_o == '0)
    else $error("core pattern without overflow");
  sticky_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    ovf_ev[0] |=> status_q[0])
    else $error("overflow flag lost");
  irq_level_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(irq_o) |-> $past(ovf_ev) != '0 || mask_q != $past(mask_q))
    else $error("interrupt rose without cause");
  wr_resp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_fire |=> s_axi_bvalid_o &&
    s_axi_bresp_o == ($past(wr_hit) ? `UQM_RESP_OKAY : `UQM_RESP_SLVERR))
    else $error("write response wrong");
endmodule

// ### pkg/uqm_defines.svh
`ifndef UQM_DEFINES_SVH
`define UQM_DEFINES_SVH
// event codes
`define UQM_EV_NOT_EMPTY    8'h00
`define UQM_EV_FULL         8'h01
`define UQM_EV_OCCUPANCY    8'h02
`define UQM_EV_ALLOCATION   8'h03
// unit masks: tracker and read sub-stage select
`define UQM_UM_READ         8'h01
`define UQM_UM_RD_MISS      8'h02
`define UQM_UM_RD_RESP      8'h04
`define UQM_UM_RD_CREDIT    8'h08
`define UQM_UM_WRITEBACK    8'h10
`define UQM_UM_PEER         8'h20
// tracker depths
`define UQM_RD_DEPTH        32
`define UQM_WB_DEPTH        16
`define UQM_PEER_DEPTH      12
// register byte offsets
`define UQM_OFF_CTRL        12'h000
`define UQM_OFF_STATUS      12'h004
`define UQM_OFF_MASK        12'h008
`define UQM_OFF_CORE_SEL    12'h00C
`define UQM_OFF_FIXED       12'h010
`define UQM_OFF_SEL_BASE    12'h040
`define UQM_OFF_CNT_BASE    12'h080
// select register fields
`define UQM_SEL_EVT_LSB     0
`define UQM_SEL_UM_LSB      8
`define UQM_SEL_THR_LSB     16
`define UQM_SEL_EN_BIT      31
// status bit of the fixed counter
`define UQM_FIXED_BIT       8
`define UQM_RESP_OKAY       2'h0
`define UQM_RESP_SLVERR     2'h2
`endif

// ### pkg/uqm_pkg.sv
package uqm_pkg;
  typedef enum logic [1:0] {
    UQM_TRK_READ,
    UQM_TRK_WB,
    UQM_TRK_PEER
  } uqm_tracker_type;
  // per-tracker sample of the shared request queue
  typedef struct packed {
    logic [5:0] valid_cnt;
    logic       insert;
    logic       full;
  } uqm_trk_sample_type;
  typedef enum logic [1:0] {
    UQM_RD_IDLE,
    UQM_RD_RESP
  } uqm_rd_state_type;
endpackage

// ### pkg/uqm_evt_if.sv
interface uqm_evt_if #(parameter int W = 48);
  logic [7:0]  evt_code;
  logic [7:0]  unit_mask;
  logic [7:0]  threshold;
  logic        enable;
  logic [W-1:0] count;
  logic        overflow;
  modport ctrl (output evt_code, output unit_mask, output threshold, output enable,
                input count, input overflow);
  modport cnt  (input evt_code, input unit_mask, input threshold, input enable,
                output count, output overflow);
endinterface

// ### design/uqm_counter.sv
`include "uqm_defines.svh"
module uqm_counter #(
  parameter int W = 48
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  uqm_evt_if.cnt                             cfg,
  input  wire uqm_pkg::uqm_trk_sample_type   samp_i [6],
  input  wire logic                          load_i,
  input  wire logic [31:0]                   load_data_i
);
  import uqm_pkg::*;
  logic [W-1:0] cnt_q;
  logic         ovf_q;
  logic [5:0]   occ [6];
  logic         ins [6];
  logic         ful [6];
  logic [5:0]   sel_occ;
  logic         sel_ins;
  logic         sel_ful;
  logic         sel_ne;
  logic [5:0]   occ_inc;
  logic [5:0]   inc;
  logic [W:0]   sum;
  // unit mask picks one tracker or read stage; lowest bit wins
  always_comb begin
    sel_occ = 6'h0;
    sel_ins = 1'b0;
    sel_ful = 1'b0;
    for (int k = 5; k >= 0; k--) begin
      if (cfg.unit_mask[k]) begin
        sel_occ = occ[k];
        sel_ins = ins[k];
        sel_ful = ful[k];
      end
    end
  end
  for (genvar k = 0; k < 6; k++) begin : g_s
    assign occ[k] = samp_i[k].valid_cnt;
    assign ins[k] = samp_i[k].insert;
    assign ful[k] = samp_i[k].full;
  end
  assign sel_ne  = (sel_occ != 6'h0);
  // threshold 1 gives busy cycles, 32 gives read full cycles
  assign occ_inc = (cfg.threshold == 8'h0) ? sel_occ :
                   {5'h0, ({2'h0, sel_occ} >= cfg.threshold)};
  always_comb begin
    case (cfg.evt_code)
      `UQM_EV_NOT_EMPTY:  inc = {5'h0, sel_ne};
      `UQM_EV_FULL:       inc = {5'h0, sel_ful};
      `UQM_EV_OCCUPANCY:  inc = occ_inc;
      `UQM_EV_ALLOCATION: inc = {5'h0, sel_ins};
      default:            inc = 6'h0;
    endcase
  end
  assign sum = {1'b0, cnt_q} + {{(W-5){1'b0}}, inc};
  // overflow is a one-cycle pulse; no source identity is kept
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (load_i) begin
      cnt_q <= W'(load_data_i);
      ovf_q <= 1'b0;
    end else if (cfg.enable) begin
      cnt_q <= sum[W-1:0];
      ovf_q <= sum[W];
    end else begin
      ovf_q <= 1'b0;
    end
  end
  assign cfg.count    = cnt_q;
  assign cfg.overflow = ovf_q;

  cnt_alloc_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg.enable && !load_i && cfg.evt_code == `UQM_EV_ALLOCATION && !sel_ins
    && cnt_q != '1 |=> cnt_q == $past(cnt_q))
    else $error("allocation counter moved without insert");
  busy_thr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg.enable && !load_i && cfg.evt_code == `UQM_EV_OCCUPANCY && cfg.threshold == 8'h01
    && sel_occ != 6'h0 && cnt_q != '1 |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("busy cycle not counted");
endmodule

// ### design/uqm_trackers.sv
`include "uqm_defines.svh"
module uqm_trackers (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic [2:0]                   alloc_i,
  input  wire logic [2:0]                   dealloc_i,
  input  wire logic                         rd_miss_i,
  input  wire logic                         rd_resp_i,
  input  wire logic                         rd_credit_i,
  output uqm_pkg::uqm_trk_sample_type       samp_o [6]
);
  import uqm_pkg::*;
  localparam logic [5:0] DEPTH [3] = '{6'(`UQM_RD_DEPTH), 6'(`UQM_WB_DEPTH),
                                      6'(`UQM_PEER_DEPTH)};
  logic [5:0] occ_q [3];
  logic [5:0] stg_q [3];
  logic [2:0] stg_in;
  // three trackers: local reads, local writebacks, peer-link requests
  for (genvar t = 0; t < 3; t++) begin : g_trk
    logic up;
    logic dn;
    assign up = alloc_i[t] && occ_q[t] != DEPTH[t];
    assign dn = dealloc_i[t] && occ_q[t] != 6'h0;
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) occ_q[t] <= 6'h0;
      else         occ_q[t] <= occ_q[t] + 6'(up) - 6'(dn);
    end
    assign samp_o[t == 0 ? 0 : t + 3] = '{valid_cnt: occ_q[t], insert: up,
                                          full: occ_q[t] == DEPTH[t]};
  end
  // read stages: entered on event, left on the read entry's release, which
  // follows delivery by cleanup so the total read occupancy is longer
  assign stg_in = {rd_credit_i, rd_resp_i, rd_miss_i};
  for (genvar s = 0; s < 3; s++) begin : g_stg
    logic up;
    logic dn;
    assign up = stg_in[s] && stg_q[s] != occ_q[0];
    assign dn = dealloc_i[0] && stg_q[s] != 6'h0;
    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) stg_q[s] <= 6'h0;
      else         stg_q[s] <= stg_q[s] + 6'(up) - 6'(dn);
    end
    assign samp_o[s + 1] = '{valid_cnt: stg_q[s], insert: up,
                             full: stg_q[s] == DEPTH[0]};
  end

  rd_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    occ_q[0] <= DEPTH[0] && occ_q[1] <= DEPTH[1] && occ_q[2] <= DEPTH[2])
    else $error("tracker occupancy above depth");
  stage_within_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    stg_q[0] <= occ_q[0] && stg_q[1] <= occ_q[0] && stg_q[2] <= occ_q[0])
    else $error("read stage exceeds read tracker");
endmodule

// ### tb/uqm_queue_model.sv
module uqm_queue_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       fill_i,
  output logic [2:0]      alloc_o,
  output logic [2:0]      dealloc_o,
  output logic [2:0]      stage_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   occ [3];
  int   dep [3] = '{32, 16, 12};
  int   r;
  logic a;
  logic d;
  // never inserts into a full tracker nor releases from an empty one
  always @(posedge sys_clk_i) begin
    for (int t = 0; t < 3; t++) begin
      r = $urandom % 4;
      a = rstn_i && fill_i && r != 0 && occ[t] < dep[t];
      // fill low drains all trackers before counts are read
      d = rstn_i && !a && occ[t] > 0 && (!fill_i || r == 0);
      occ[t] = rstn_i ? occ[t] + a - d : 0;
      alloc_o[t] <= a;
      dealloc_o[t] <= d;
    end
    // random read stage events only while the read tracker holds entries
    stage_o <= (occ[0] > 0) ? 3'($urandom) : 3'h0;
  end
endmodule

// ### tb/testbench.sv
`include "uqm_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CW = 16;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, halt = 1'b1, fill = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  alloc, dealloc, stage;
  wire logic [3:0]  core_sig;
  logic [3:0]  core_seen = 4'h0;
  int          failures = 0;
  int          n_compared = 0;
  longint      occ [3], s_occ [3], n_ins [3], n_full [3], n_ne [3], n_32;
  longint      ex [8];
  longint      stg [3], s_stg [3], n_stg_in [3], n_stg_busy [3];
  int          dep [3] = '{32, 16, 12};
  logic [1:0]  resp;
  logic [31:0] data, t0, sel [8];
  logic [7:0]  st;

  always #4 clk = ~clk;

  uqm_monitor #(.NCNT(8), .NCORE(4), .CW(CW)) u_uqm_monitor (
    .sys_clk_i(clk), .rstn_i(rstn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .trk_alloc_i(alloc), .trk_dealloc_i(dealloc), .rd_miss_i(stage[0]),
    .rd_resp_i(stage[1]), .rd_credit_i(stage[2]), .uncore_halt_i(halt),
    .core_signal_o(core_sig), .irq_o(irq));

  uqm_queue_model u_uqm_queue_model (
    .sys_clk_i(clk), .rstn_i(rstn), .fill_i(fill),
    .alloc_o(alloc), .dealloc_o(dealloc), .stage_o(stage));

  always @(posedge clk) if (rstn && core_sig !== 4'h0) core_seen <= core_sig;

  // reference trackers, integrated from the observed sample inputs
  always @(posedge clk) begin
    n_32 += (occ[0] >= 32);
    // read stages use the read occupancy before this edge's update
    for (int s = 0; s < 3; s++) begin
      s_stg[s] += stg[s];
      n_stg_busy[s] += (stg[s] > 0);
      n_stg_in[s] += (stage[s] === 1'b1 && stg[s] < occ[0]);
      stg[s] = rstn ? stg[s] + (stage[s] === 1'b1 && stg[s] < occ[0])
                      - (dealloc[0] === 1'b1 && stg[s] > 0) : 0;
    end
    for (int t = 0; t < 3; t++) begin
      s_occ[t] += occ[t];
      n_full[t] += (occ[t] == dep[t]);
      n_ne[t] += (occ[t] > 0);
      n_ins[t] += (alloc[t] === 1'b1 && occ[t] < dep[t]);
      occ[t] = rstn ? occ[t] + (alloc[t] && occ[t] < dep[t]) - (dealloc[t] && occ[t] > 0) : 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // queue traffic, then a full drain so every count is settled
  task automatic traffic(input int n);
    logic [1:0] r;
    fill <= 1'b1;
    repeat (n) @(posedge clk);
    fill <= 1'b0;
    for (int i = 0; i < 100 && occ[0] + occ[1] + occ[2] > 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    wr(`UQM_OFF_CTRL, 32'h0, r);
  endtask

  function automatic logic [31:0] ev(input logic [7:0] c, input logic [7:0] u,
                                     input logic [7:0] th);
    return {1'b1, 7'h00, th, u, c};
  endfunction

  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run is near 1300 cycles
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(18));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(12'(i * 4), data, resp);
      chk("reset value", data, 32'h0);
    end
    rd(12'h0FC, data, resp);
    chk("unmapped rresp", 32'(resp), 32'(`UQM_RESP_SLVERR));
    chk("unmapped rdata", data, 32'h0);
    wr(12'h0FC, 32'hFFFFFFFF, resp);
    chk("unmapped bresp", 32'(resp), 32'(`UQM_RESP_SLVERR));
    sel = '{ev(`UQM_EV_ALLOCATION, `UQM_UM_READ, 8'h00),
            ev(`UQM_EV_OCCUPANCY, `UQM_UM_READ, 8'h00),
            ev(`UQM_EV_FULL, `UQM_UM_READ, 8'h00),
            ev(`UQM_EV_NOT_EMPTY, `UQM_UM_WRITEBACK, 8'h00),
            ev(`UQM_EV_OCCUPANCY, `UQM_UM_WRITEBACK, 8'h01),
            ev(`UQM_EV_ALLOCATION, `UQM_UM_PEER, 8'h00),
            ev(`UQM_EV_OCCUPANCY, `UQM_UM_READ, 8'h20),
            ev(`UQM_EV_OCCUPANCY, `UQM_UM_PEER, 8'h00)};
    for (int i = 0; i < 8; i++) wr(`UQM_OFF_SEL_BASE + 12'(4 * i), sel[i], resp);
    wr(`UQM_OFF_CNT_BASE, 32'h0000FFF0, resp);
    wr(`UQM_OFF_MASK, 32'h1, resp);
    wr(`UQM_OFF_CORE_SEL, 32'hA, resp);
    wr(`UQM_OFF_CTRL, 32'h1, resp);
    rd(`UQM_OFF_FIXED, t0, resp);
    repeat (10) @(posedge clk);
    rd(`UQM_OFF_FIXED, data, resp);
    chk("fixed halted", data, t0);
    halt <= 1'b0;
    rd(`UQM_OFF_FIXED, t0, resp);
    repeat (10) @(posedge clk);
    rd(`UQM_OFF_FIXED, data, resp);
    chk("fixed runs", 32'(16'(data - t0) >= 16'd10), 32'h1);
    traffic(600);
    ex = '{16'hFFF0 + n_ins[0], s_occ[0], n_full[0], n_ne[1],
           n_ne[1], n_ins[2], n_32, s_occ[2]};
    for (int i = 0; i < 8; i++) begin
      rd(`UQM_OFF_CNT_BASE + 12'(4 * i), data, resp);
      chk("counter", data, 32'(ex[i] % (64'd1 << CW)));
      st[i] = ex[i] >= (64'd1 << CW);
    end
    rd(`UQM_OFF_STATUS, data, resp);
    chk("overflow status", data & 32'hFF, 32'(st));
    chk("irq raised", 32'(irq), 32'(st[0]));
    chk("core pattern", 32'(core_seen), st[0] ? 32'hA : 32'h0);
    wr(`UQM_OFF_STATUS, 32'h1FF, resp);
    rd(`UQM_OFF_STATUS, data, resp);
    chk("status cleared", data & 32'hFF, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    // second pass: read processing stages
    wr(`UQM_OFF_SEL_BASE, ev(`UQM_EV_ALLOCATION, `UQM_UM_RD_MISS, 8'h00), resp);
    wr(`UQM_OFF_SEL_BASE + 12'h004, ev(`UQM_EV_OCCUPANCY, `UQM_UM_RD_RESP, 8'h00), resp);
    wr(`UQM_OFF_SEL_BASE + 12'h008, ev(`UQM_EV_OCCUPANCY, `UQM_UM_RD_CREDIT, 8'h01), resp);
    for (int i = 0; i < 3; i++) wr(`UQM_OFF_CNT_BASE + 12'(4 * i), 32'h0, resp);
    ex[0] = n_stg_in[0];
    ex[1] = s_stg[1];
    ex[2] = n_stg_busy[2];
    wr(`UQM_OFF_CTRL, 32'h1, resp);
    traffic(400);
    ex[0] = n_stg_in[0] - ex[0];
    ex[1] = s_stg[1] - ex[1];
    ex[2] = n_stg_busy[2] - ex[2];
    for (int i = 0; i < 3; i++) begin
      rd(`UQM_OFF_CNT_BASE + 12'(4 * i), data, resp);
      chk("stage counter", data, 32'(ex[i] % (64'd1 << CW)));
    end
    tally_and_finish;
  end
endmodule
